/* File: src/dual_port_pin_controller_cfg.svh */
// Register offsets, field positions, reset values and routing constants
`ifndef DUAL_PORT_PIN_CONTROLLER_CFG_SVH
`define DUAL_PORT_PIN_CONTROLLER_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_SECOND_PORT_PINS      32'h0000_0000
`define OFS_SECOND_PORT_LATCH     32'h0000_0004
`define OFS_SECOND_PORT_DIRECTION 32'h0000_0008
`define OFS_INTERRUPT_CTRL_FIRST  32'h0000_000c
`define OFS_INTERRUPT_CTRL_SECOND 32'h0000_0010
`define OFS_INTERRUPT_CTRL_THIRD  32'h0000_0014
`define OFS_THIRD_PORT_PINS       32'h0000_0018
`define OFS_THIRD_PORT_LATCH      32'h0000_001c
`define OFS_THIRD_PORT_DIRECTION  32'h0000_0020
`define OFS_ROUTING_STATUS        32'h0000_0024

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_DIRECTION             8'hff
`define RST_INTERRUPT_CTRL_FIRST  8'h00
`define RST_INTERRUPT_CTRL_SECOND 8'hff
`define RST_INTERRUPT_CTRL_THIRD  8'hc0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_PORT_CHANGE_FLAG      0
`define BIT_EXT_ZERO_FLAG         1
`define BIT_EXT_ONE_FLAG          0
`define BIT_EXT_TWO_FLAG          1
`define BIT_EXT_THREE_FLAG        2
`define BIT_PULLUP_CONTROL        7
`define BIT_EDGE_SEL_ZERO         6
`define BIT_EDGE_SEL_ONE          5
`define BIT_EDGE_SEL_TWO          4
`define BIT_EDGE_SEL_THREE        3
`define BIT_CAPTURE_TWO_PIN       3
`define BIT_CAPTURE_TWO_ALT       1

// ----------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------
`define RESP_OKAY                 2'h0
`define RESP_SLVERR               2'h2

`endif

/* File: src/dual_port_pin_controller_pkg.sv */
// Types shared by the dual port pin controller
package dual_port_pin_controller_pkg;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;

    typedef enum logic [3:0] {
        REG_SECOND_PINS = 4'h0,
        REG_SECOND_LATCH = 4'h1,
        REG_SECOND_DIR = 4'h2,
        REG_INTCTL_FIRST = 4'h3,
        REG_INTCTL_SECOND = 4'h4,
        REG_INTCTL_THIRD = 4'h5,
        REG_THIRD_PINS = 4'h6,
        REG_THIRD_LATCH = 4'h7,
        REG_THIRD_DIR = 4'h8,
        REG_ROUTING = 4'h9,
        REG_NONE = 4'hf
    } reg_sel_t;

    typedef enum logic [0:0] {
        WR_COLLECT = 1'b0,
        WR_RESPOND = 1'b1
    } wr_state_t;

endpackage : dual_port_pin_controller_pkg

/* File: src/dual_port_pin_controller.sv */
// Second and third general purpose ports with AXI4-Lite register access
//
// Overview of operation
// - Each port has eight pins, each usable as input or output.
// - Direction bit 1 turns the pin driver off; pin is an input.
// - Direction bit 0 drives the pin from its output latch.
// - Pin register reads return pin levels; writes go to the output latch.
// - Output latch has its own address and reads back the stored value.
// - Enabled third-port peripherals may force a pin to output or input.
// - Peripheral direction override never changes the direction register.
// - Every reset sets both direction registers to all ones.
// - Pin and latch contents are undefined at power-up and kept across resets.
// - Second-port pins 0 to 3 are external interrupt inputs 0 to 3.
// - Second-port pins 4 to 7 have change detection besides normal I/O.
// - Any change on second-port pins 7 to 4 sets the port change flag.
// - Clearing shared bit 7 of second interrupt control enables weak pull-ups on second-port input pins.
// - Second-port pin 3 can carry the second capture unit's pin function.
// - Routing bit set sends second capture unit to third-port pin 1.
// - Routing bit clear: fifth-port pin 7 in micro mode, else pin 3 on larger package.
// - Second-port pins 5, 6, 7 serve low-voltage programming signals.
// - Third-port pins 0 to 2 carry oscillator, timer clock, capture one.
// - Third-port pins 3 to 5 carry synchronous serial clock and data.
// - Third-port pins 6 and 7 carry first USART lines.
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "dual_port_pin_controller_cfg.svh"

module dual_port_pin_controller
    import dual_port_pin_controller_pkg::*;
#(
    parameter int PORT_WIDTH = 8
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire axil_req_t axil_req_in,
    output axil_rsp_t axil_rsp_out,
    input wire logic [PORT_WIDTH-1:0] second_port_pins_in,
    output logic [PORT_WIDTH-1:0] second_port_pins_out,
    output logic [PORT_WIDTH-1:0] second_port_pins_oe_out,
    output logic [PORT_WIDTH-1:0] second_port_pullup_out,
    input wire logic [PORT_WIDTH-1:0] third_port_pins_in,
    output logic [PORT_WIDTH-1:0] third_port_pins_out,
    output logic [PORT_WIDTH-1:0] third_port_pins_oe_out,
    input wire logic [PORT_WIDTH-1:0] third_periph_enable_in,
    input wire logic [PORT_WIDTH-1:0] third_periph_input_in,
    input wire logic [PORT_WIDTH-1:0] third_periph_data_in,
    input wire logic capture_two_pin_select_in,
    input wire logic micro_mode_in,
    input wire logic large_package_in,
    input wire logic capture_two_enable_in,
    input wire logic capture_two_input_in,
    input wire logic capture_two_data_in,
    output logic capture_two_to_fifth_out,
    output logic [PORT_WIDTH-1:0] second_port_levels_out,
    output logic [PORT_WIDTH-1:0] third_port_levels_out
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic reg_sel_t decode_addr(input logic [31:0] addr);
        case (addr)
            `OFS_SECOND_PORT_PINS: decode_addr = REG_SECOND_PINS;
            `OFS_SECOND_PORT_LATCH: decode_addr = REG_SECOND_LATCH;
            `OFS_SECOND_PORT_DIRECTION: decode_addr = REG_SECOND_DIR;
            `OFS_INTERRUPT_CTRL_FIRST: decode_addr = REG_INTCTL_FIRST;
            `OFS_INTERRUPT_CTRL_SECOND: decode_addr = REG_INTCTL_SECOND;
            `OFS_INTERRUPT_CTRL_THIRD: decode_addr = REG_INTCTL_THIRD;
            `OFS_THIRD_PORT_PINS: decode_addr = REG_THIRD_PINS;
            `OFS_THIRD_PORT_LATCH: decode_addr = REG_THIRD_LATCH;
            `OFS_THIRD_PORT_DIRECTION: decode_addr = REG_THIRD_DIR;
            `OFS_ROUTING_STATUS: decode_addr = REG_ROUTING;
            default: decode_addr = REG_NONE;
        endcase
    endfunction : decode_addr

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [PORT_WIDTH-1:0] second_latch_r;
    logic [PORT_WIDTH-1:0] third_latch_r;
    logic [PORT_WIDTH-1:0] second_dir_r;
    logic [PORT_WIDTH-1:0] third_dir_r;
    logic [7:0] intctl_first_r;
    logic [7:0] intctl_second_r;
    logic [7:0] intctl_third_r;
    logic [7:0] intctl_first_nxt;
    logic [7:0] intctl_third_nxt;

    logic [PORT_WIDTH-1:0] second_meta_r;
    logic [PORT_WIDTH-1:0] second_sync_r;
    logic [PORT_WIDTH-1:0] second_prev_r;
    logic [PORT_WIDTH-1:0] third_meta_r;
    logic [PORT_WIDTH-1:0] third_sync_r;

    wr_state_t wr_state_r;
    logic aw_held_r;
    logic w_held_r;
    logic [31:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    logic do_write;
    reg_sel_t wr_sel;
    reg_sel_t rd_sel;
    logic [7:0] wr_byte;
    logic wr_lane;

    logic route_to_third;
    logic route_to_second;
    logic [PORT_WIDTH-1:0] second_ovr_en;
    logic [PORT_WIDTH-1:0] second_ovr_in;
    logic [PORT_WIDTH-1:0] second_ovr_data;
    logic [PORT_WIDTH-1:0] third_ovr_en;
    logic [PORT_WIDTH-1:0] third_ovr_in;
    logic [PORT_WIDTH-1:0] third_ovr_data;
    logic [PORT_WIDTH-1:0] second_eff_input;
    logic [PORT_WIDTH-1:0] third_eff_input;
    logic [3:0] ext_edge;
    logic change_seen;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        second_meta_r <= second_port_pins_in;
        second_sync_r <= second_meta_r;
        third_meta_r <= third_port_pins_in;
        third_sync_r <= third_meta_r;
        second_prev_r <= second_sync_r;
    end

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    assign do_write = (wr_state_r == WR_COLLECT) && aw_held_r && w_held_r;
    assign wr_sel = decode_addr(awaddr_r);
    assign wr_byte = wdata_r[7:0];
    assign wr_lane = do_write && wstrb_r[0];

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            wr_state_r <= WR_COLLECT;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 32'h0000_0000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
        end else begin
            if (axil_req_in.awvalid && awready_r) begin
                aw_held_r <= 1'b1;
                awaddr_r <= axil_req_in.awaddr;
                awready_r <= 1'b0;
            end
            if (axil_req_in.wvalid && wready_r) begin
                w_held_r <= 1'b1;
                wdata_r <= axil_req_in.wdata;
                wstrb_r <= axil_req_in.wstrb;
                wready_r <= 1'b0;
            end
            case (wr_state_r)
                WR_COLLECT: begin
                    if (do_write) begin
                        wr_state_r <= WR_RESPOND;
                        bvalid_r <= 1'b1;
                        bresp_r <= (wr_sel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
                    end
                end
                WR_RESPOND: begin
                    if (axil_req_in.bready) begin
                        wr_state_r <= WR_COLLECT;
                        bvalid_r <= 1'b0;
                        aw_held_r <= 1'b0;
                        w_held_r <= 1'b0;
                        awready_r <= 1'b1;
                        wready_r <= 1'b1;
                    end
                end
                default: begin
                    wr_state_r <= WR_COLLECT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Output latches, no reset so contents survive resets
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (wr_lane && (wr_sel == REG_SECOND_PINS || wr_sel == REG_SECOND_LATCH)) begin
            second_latch_r <= wr_byte;
        end
        if (wr_lane && (wr_sel == REG_THIRD_PINS || wr_sel == REG_THIRD_LATCH)) begin
            third_latch_r <= wr_byte;
        end
    end

    // ------------------------------------------------------------------
    // Direction registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            second_dir_r <= `RST_DIRECTION;
            third_dir_r <= `RST_DIRECTION;
        end else begin
            if (wr_lane && wr_sel == REG_SECOND_DIR) begin
                second_dir_r <= wr_byte;
            end
            if (wr_lane && wr_sel == REG_THIRD_DIR) begin
                third_dir_r <= wr_byte;
            end
        end
    end

    // ------------------------------------------------------------------
    // External interrupt and change detection
    // ------------------------------------------------------------------
    always_comb begin
        // Edge seen and new level equals selected polarity
        for (int i = 0; i < 4; i++) begin
            ext_edge[i] = (second_sync_r[i] ^ second_prev_r[i])
                && (second_sync_r[i] == intctl_second_r[`BIT_EDGE_SEL_ZERO - i]);
        end
        change_seen = |(second_sync_r[7:4] ^ second_prev_r[7:4]);
    end

    // Software write first, hardware set wins over a clear
    always_comb begin
        intctl_first_nxt = intctl_first_r;
        intctl_third_nxt = intctl_third_r;
        if (wr_lane && wr_sel == REG_INTCTL_FIRST) begin
            intctl_first_nxt = wr_byte;
        end
        if (wr_lane && wr_sel == REG_INTCTL_THIRD) begin
            intctl_third_nxt = wr_byte;
        end
        intctl_first_nxt[`BIT_PORT_CHANGE_FLAG] = intctl_first_nxt[`BIT_PORT_CHANGE_FLAG] | change_seen;
        intctl_first_nxt[`BIT_EXT_ZERO_FLAG] = intctl_first_nxt[`BIT_EXT_ZERO_FLAG] | ext_edge[0];
        intctl_third_nxt[`BIT_EXT_THREE_FLAG:`BIT_EXT_ONE_FLAG] |= ext_edge[3:1];
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            intctl_first_r <= `RST_INTERRUPT_CTRL_FIRST;
            intctl_second_r <= `RST_INTERRUPT_CTRL_SECOND;
            intctl_third_r <= `RST_INTERRUPT_CTRL_THIRD;
        end else begin
            intctl_first_r <= intctl_first_nxt;
            intctl_third_r <= intctl_third_nxt;
            if (wr_lane && wr_sel == REG_INTCTL_SECOND) begin
                intctl_second_r <= wr_byte;
            end
        end
    end

    // ------------------------------------------------------------------
    // Peripheral routing and direction override
    // ------------------------------------------------------------------
    assign route_to_third = capture_two_pin_select_in;
    assign route_to_second = !capture_two_pin_select_in && !micro_mode_in && large_package_in;

    always_comb begin
        second_ovr_en = '0;
        second_ovr_in = '0;
        second_ovr_data = '0;
        third_ovr_en = third_periph_enable_in;
        third_ovr_in = third_periph_input_in;
        third_ovr_data = third_periph_data_in;
        if (capture_two_enable_in && route_to_second) begin
            second_ovr_en[`BIT_CAPTURE_TWO_PIN] = 1'b1;
            second_ovr_in[`BIT_CAPTURE_TWO_PIN] = capture_two_input_in;
            second_ovr_data[`BIT_CAPTURE_TWO_PIN] = capture_two_data_in;
        end
        if (capture_two_enable_in && route_to_third) begin
            third_ovr_en[`BIT_CAPTURE_TWO_ALT] = 1'b1;
            third_ovr_in[`BIT_CAPTURE_TWO_ALT] = capture_two_input_in;
            third_ovr_data[`BIT_CAPTURE_TWO_ALT] = capture_two_data_in;
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < PORT_WIDTH; g++) begin : g_pin
            assign second_eff_input[g] = second_ovr_en[g] ? second_ovr_in[g] : second_dir_r[g];
            assign third_eff_input[g] = third_ovr_en[g] ? third_ovr_in[g] : third_dir_r[g];

            always_ff @(posedge ref_clk_in) begin
                if (!resetn_in) begin
                    second_port_pins_oe_out[g] <= 1'b0;
                    second_port_pins_out[g] <= 1'b0;
                    second_port_pullup_out[g] <= 1'b0;
                    third_port_pins_oe_out[g] <= 1'b0;
                    third_port_pins_out[g] <= 1'b0;
                end else begin
                    second_port_pins_oe_out[g] <= !second_eff_input[g];
                    second_port_pins_out[g] <= second_eff_input[g] ? 1'b0
                        : (second_ovr_en[g] ? second_ovr_data[g] : second_latch_r[g]);
                    second_port_pullup_out[g] <= second_eff_input[g]
                        && !intctl_second_r[`BIT_PULLUP_CONTROL];
                    third_port_pins_oe_out[g] <= !third_eff_input[g];
                    third_port_pins_out[g] <= third_eff_input[g] ? 1'b0
                        : (third_ovr_en[g] ? third_ovr_data[g] : third_latch_r[g]);
                end
            end
        end
    endgenerate

    // Levels for serial programming and peripheral inputs
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            second_port_levels_out <= '0;
            third_port_levels_out <= '0;
            capture_two_to_fifth_out <= 1'b0;
        end else begin
            second_port_levels_out <= second_sync_r;
            third_port_levels_out <= third_sync_r;
            capture_two_to_fifth_out <= !capture_two_pin_select_in && micro_mode_in;
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    assign rd_sel = decode_addr(axil_req_in.araddr);

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `RESP_OKAY;
        end else if (axil_req_in.arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= `RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            case (rd_sel)
                REG_SECOND_PINS: rdata_r[7:0] <= second_sync_r;
                REG_SECOND_LATCH: rdata_r[7:0] <= second_latch_r;
                REG_SECOND_DIR: rdata_r[7:0] <= second_dir_r;
                REG_INTCTL_FIRST: rdata_r[7:0] <= intctl_first_r;
                REG_INTCTL_SECOND: rdata_r[7:0] <= intctl_second_r;
                REG_INTCTL_THIRD: rdata_r[7:0] <= intctl_third_r;
                REG_THIRD_PINS: rdata_r[7:0] <= third_sync_r;
                REG_THIRD_LATCH: rdata_r[7:0] <= third_latch_r;
                REG_THIRD_DIR: rdata_r[7:0] <= third_dir_r;
                REG_ROUTING: rdata_r[3:0] <= {capture_two_enable_in, large_package_in,
                                              micro_mode_in, capture_two_pin_select_in};
                default: rresp_r <= `RESP_SLVERR;
            endcase
        end else if (rvalid_r && axil_req_in.rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    assign axil_rsp_out = '{
        awready_r, wready_r, bvalid_r, bresp_r,
        arready_r, rvalid_r, rdata_r, rresp_r
    };

endmodule : dual_port_pin_controller

/* File: bench/dual_port_pin_controller_assertions.sv */
// Port checks for the dual port pin controller
`timescale 1ns/1ns
module pin_ctl_checker
    import dual_port_pin_controller_pkg::*;
#(
    parameter int PORT_WIDTH = 8
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire axil_req_t axil_req_in,
    input wire axil_rsp_t axil_rsp_out,
    input wire logic [PORT_WIDTH-1:0] second_port_pins_out,
    input wire logic [PORT_WIDTH-1:0] second_port_pins_oe_out,
    input wire logic [PORT_WIDTH-1:0] second_port_pullup_out,
    input wire logic [PORT_WIDTH-1:0] third_port_pins_oe_out,
    input wire logic [PORT_WIDTH-1:0] third_periph_enable_in,
    input wire logic [PORT_WIDTH-1:0] third_periph_input_in
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    sequence wr_taken;
        axil_req_in.awvalid && axil_rsp_out.awready && axil_req_in.wvalid && axil_rsp_out.wready;
    endsequence
    sequence wr_answer;
        !axil_rsp_out.awready ##1 axil_rsp_out.bvalid;
    endsequence
    AST_WR_LAT: assert property (wr_taken |=> wr_answer) else $error("write answer late");
    AST_RD_LAT: assert property (axil_req_in.arvalid && axil_rsp_out.arready |=> axil_rsp_out.rvalid)
        else $error("read answer late");
    AST_AR_BUSY: assert property (axil_rsp_out.rvalid |-> !axil_rsp_out.arready) else $error("read overlap");
    AST_RST_DIR: assert property (disable iff (1'b0) !resetn_in |=> second_port_pins_oe_out == '0
        && third_port_pins_oe_out == '0) else $error("pins driven after reset");
    AST_MASK: assert property ((second_port_pins_out & ~second_port_pins_oe_out) == '0)
        else $error("undriven pin carries data");
    AST_PU: assert property ((second_port_pullup_out & second_port_pins_oe_out) == '0)
        else $error("pull-up on driven pin");
    AST_FOUT: assert property (third_periph_enable_in[0] && !third_periph_input_in[0]
        |=> third_port_pins_oe_out[0]) else $error("force output ignored");
    AST_FIN: assert property (third_periph_enable_in[7] && third_periph_input_in[7]
        |=> !third_port_pins_oe_out[7]) else $error("force input ignored");
endmodule : pin_ctl_checker

/* File: bench/pin_far_side.sv */
// External circuitry on both ports, resolving each pin
`timescale 1ns/1ns
module pin_far_side (
    input wire logic clk_in,
    input wire logic [15:0] oe_in,
    input wire logic [15:0] drv_in,
    input wire logic [15:0] pu_in,
    input wire logic [15:0] ext_en_in,
    input wire logic [15:0] ext_val_in,
    output logic [15:0] pins_out
);
    logic flip_r = 1'b0;
    always @(posedge clk_in) flip_r <= ~flip_r;
    // Floating pins wander every cycle
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pins_out[i] = oe_in[i] ? drv_in[i] : ext_en_in[i] ? ext_val_in[i] : pu_in[i] ? 1'b1 : flip_r;
        end
    end
endmodule : pin_far_side

/* File: bench/tb_dual_port_pin_controller.sv */
// Self-checking bench for the dual port pin controller
`timescale 1ns/1ns
`include "dual_port_pin_controller_cfg.svh"
module tb_dual_port_pin_controller;
    import dual_port_pin_controller_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    axil_req_t q = '0;
    axil_rsp_t s;
    logic [15:0] lv;
    logic [7:0] p2o, p2e, pu, p3o, p3e, lat, dir, ev, l2, l3;
    logic c5;
    logic [7:0] x2e = 8'hff, x2v = '0, pe = '0, pi = '0, pd = '0;
    logic [5:0] mx = 6'h01;
    logic [31:0] d;
    logic [1:0] r;
    int n_fail = 0, n_tests = 0, seed = 32'hf0dc;
    always #4 clk = ~clk;
    dual_port_pin_controller dual_port_pin_controller_i (.ref_clk_in(clk), .resetn_in(rstn), .axil_req_in(q),
        .axil_rsp_out(s), .second_port_pins_in(lv[7:0]), .second_port_pins_out(p2o), .second_port_pins_oe_out(p2e),
        .second_port_pullup_out(pu), .third_port_pins_in(lv[15:8]), .third_port_pins_out(p3o),
        .third_port_pins_oe_out(p3e), .third_periph_enable_in(pe), .third_periph_input_in(pi),
        .third_periph_data_in(pd), .capture_two_pin_select_in(mx[0]), .micro_mode_in(mx[1]),
        .large_package_in(mx[2]), .capture_two_enable_in(mx[3]), .capture_two_input_in(mx[4]),
        .capture_two_data_in(mx[5]), .capture_two_to_fifth_out(c5), .second_port_levels_out(l2),
        .third_port_levels_out(l3));
    pin_far_side pin_far_side_i (.clk_in(clk), .oe_in({p3e, p2e}), .drv_in({p3o, p2o}), .pu_in({8'h00, pu}),
        .ext_en_in({8'h00, x2e}), .ext_val_in({8'h00, x2v}), .pins_out(lv));
    function automatic logic [7:0] pinv(input logic [7:0] dr, lt, ex);
        return (~dr & lt) | (dr & ex);
    endfunction : pinv
    task automatic ck(input logic [33:0] g, e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : ck
    task automatic wr(input logic [31:0] a, v);
        @(posedge clk);
        q.awvalid <= 1'b1;
        q.awaddr <= a;
        q.wvalid <= 1'b1;
        q.wdata <= v;
        q.wstrb <= 4'hf;
        q.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s.awready) q.awvalid <= 1'b0;
            if (s.wready) q.wvalid <= 1'b0;
            r = s.bresp;
            if (s.bvalid) q.bready <= 1'b0;
        end while (!s.bvalid);
    endtask : wr
    task automatic rd(input logic [31:0] a);
        @(posedge clk);
        q.arvalid <= 1'b1;
        q.araddr <= a;
        q.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s.arready) q.arvalid <= 1'b0;
            d = s.rdata;
            r = s.rresp;
            if (s.rvalid) q.rready <= 1'b0;
        end while (!s.rvalid);
    endtask : rd
    task automatic rc(input logic [31:0] a, input logic [7:0] e);
        rd(a);
        ck(d, {24'h0, e});
    endtask : rc
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    initial begin
        #100000;
        n_fail++;
        wrap_up;
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rc(`OFS_SECOND_PORT_DIRECTION, 8'hff);
        rc(`OFS_THIRD_PORT_DIRECTION, 8'hff);
        rc(`OFS_INTERRUPT_CTRL_SECOND, 8'hff);
        rd(32'h40);
        ck({d, r}, {32'h0, `RESP_SLVERR});
        wr(32'h44, 32'h0);
        ck(r, `RESP_SLVERR);
        $display("test reset and map done");
        for (int k = 0; k < 8; k++) begin
            lat = 8'($random(seed));
            dir = 8'($random(seed));
            ev = 8'($random(seed));
            mx <= 6'($random(seed)) | 6'h01;
            x2e <= dir;
            x2v <= ev;
            wr(k[0] ? `OFS_SECOND_PORT_PINS : `OFS_SECOND_PORT_LATCH, {24'h0, lat});
            wr(`OFS_SECOND_PORT_DIRECTION, {24'h0, dir});
            repeat (4) @(posedge clk);
            ck({p2e, p2o}, {~dir, ~dir & lat});
            rc(`OFS_SECOND_PORT_LATCH, lat);
            rc(`OFS_SECOND_PORT_PINS, pinv(dir, lat, ev));
            rc(`OFS_ROUTING_STATUS, {4'h0, mx[3:0]});
        end
        $display("test random pins done");
        x2e <= 8'hff;
        x2v <= 8'h00;
        wr(`OFS_SECOND_PORT_DIRECTION, 32'hff);
        repeat (5) @(posedge clk);
        wr(`OFS_INTERRUPT_CTRL_FIRST, 32'h0);
        wr(`OFS_INTERRUPT_CTRL_THIRD, 32'hc0);
        x2v <= 8'h1f;
        repeat (5) @(posedge clk);
        ck(l2, 8'h1f);
        rc(`OFS_INTERRUPT_CTRL_FIRST, 8'h03);
        rc(`OFS_INTERRUPT_CTRL_THIRD, 8'hc7);
        $display("test flags done");
        wr(`OFS_INTERRUPT_CTRL_SECOND, 32'h7f);
        repeat (2) @(posedge clk);
        ck(pu, 8'hff);
        wr(`OFS_SECOND_PORT_DIRECTION, 32'h0f);
        repeat (2) @(posedge clk);
        ck(pu, 8'h0f);
        $display("test pull-ups done");
        mx <= 6'h01;
        wr(`OFS_THIRD_PORT_LATCH, 32'h0);
        wr(`OFS_THIRD_PORT_DIRECTION, 32'h0);
        pe <= 8'h81;
        pi <= 8'h80;
        pd <= 8'h01;
        repeat (3) @(posedge clk);
        ck({p3e, p3o}, 16'h7f01);
        rc(`OFS_THIRD_PORT_DIRECTION, 8'h00);
        ck(l3[6:0], 7'h01);
        mx <= 6'h29;
        repeat (2) @(posedge clk);
        ck({p3e[1], p3o[1], c5}, 3'b110);
        mx <= 6'h2c;
        repeat (2) @(posedge clk);
        ck({p2e[3], p2o[3], c5}, 3'b110);
        mx <= 6'h2a;
        repeat (2) @(posedge clk);
        ck({p2e[3], c5}, 2'b01);
        $display("test override done");
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rc(`OFS_SECOND_PORT_LATCH, lat);
        rc(`OFS_SECOND_PORT_DIRECTION, 8'hff);
        rc(`OFS_THIRD_PORT_DIRECTION, 8'hff);
        $display("test second reset done");
        wrap_up;
    end
endmodule : tb_dual_port_pin_controller
bind dual_port_pin_controller pin_ctl_checker #(.PORT_WIDTH(PORT_WIDTH)) pin_ctl_checker_i (.ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in), .axil_req_in(axil_req_in), .axil_rsp_out(axil_rsp_out),
    .second_port_pins_out(second_port_pins_out), .second_port_pins_oe_out(second_port_pins_oe_out),
    .second_port_pullup_out(second_port_pullup_out), .third_port_pins_oe_out(third_port_pins_oe_out),
    .third_periph_enable_in(third_periph_enable_in), .third_periph_input_in(third_periph_input_in));
